/* pkg/ssel_defs.svh */
/*
  Constants of the servo status and encoder select block: feedback type codes,
  output routing codes, serial frame layout, widths and timing.
  Assumes it is included by bare name; holds definitions only.
*/
`ifndef SSEL_DEFS_SVH
`define SSEL_DEFS_SVH

`define SSEL_FB_QUAD      2'h0
`define SSEL_FB_SER_INC   2'h1
`define SSEL_FB_SER_ABS   2'h2

`define SSEL_RT_NONE      4'h0
`define SSEL_RT_MATCH     4'h1
`define SSEL_RT_WARN_A    4'h2
`define SSEL_RT_WARN_B    4'h3
`define SSEL_RT_POS_CMD   4'h4
`define SSEL_RT_SPD_LIM   4'h5
`define SSEL_RT_ALM_CLR   4'h6
`define SSEL_RT_SPD_CMD   4'h7
`define SSEL_RT_ZERO_SPD  4'h8

`define SSEL_TERMINALS    6
`define SSEL_SPD_W        16
`define SSEL_POS_W        32
`define SSEL_SER_POS_W    16
`define SSEL_TEMP_W       8
`define SSEL_FRAME_W      28

`define SSEL_CLK_HZ       50000000
`define SSEL_QUAD_MAX_PPS 4000000
`define SSEL_QUAD_MIN_GAP (`SSEL_CLK_HZ / `SSEL_QUAD_MAX_PPS)

`endif

/* pkg/ssel_pkg.sv */
/*
  Types of the servo status and encoder select block.
  Assumes ssel_defs.svh is on the include path.
*/
`include "ssel_defs.svh"

package ssel_pkg;

  typedef logic [3:0] ssel_route_t;

  typedef struct packed {
    logic zero_speed_out;
    logic speed_cmd_out;
    logic alarm_clearable_out;
    logic speed_limit_out;
    logic pos_cmd_out;
    logic warning_out_b;
    logic warning_out_a;
    logic speed_match_out;
  } ssel_status_s;

  typedef struct packed {
    logic pos_cmd_active;
    logic force_ctrl_mode;
    logic speed_clamped;
    logic alarm_active;
    logic alarm_clearable;
    logic speed_ctrl_mode;
    logic speed_cmd_active;
  } ssel_cond_s;

  typedef struct packed {
    logic [`SSEL_TEMP_W-1:0]    temp;
    logic [2:0]                 hall;
    logic                       hall_valid;
    logic [`SSEL_SER_POS_W-1:0] pos;
  } ssel_frame_s;

  typedef enum logic [2:0] {SER_IDLE, SER_REQ, SER_WAIT, SER_RECV, SER_STOP} ssel_ser_e;

endpackage

/* hdl/ssel_top.sv */
/*
  Status outputs with terminal routing, and feedback encoder selection with a
  quadrature decoder and a half-duplex serial frame receiver.
  Assumes inputs synchronous to clk; serial pair resolved outside from oe.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssel_defs.svh"

module ssel_top
  import ssel_pkg::*;
#(
  parameter int POLL_CYC    = 1000,
  parameter int BIT_CYC     = 5,
  parameter int TIMEOUT_CYC = 200
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      en,
  input  wire logic signed [`SSEL_SPD_W-1:0] cmd_speed,
  input  wire logic signed [`SSEL_SPD_W-1:0] act_speed,
  input  wire logic [`SSEL_SPD_W-1:0]    speed_match_width,
  input  wire logic [`SSEL_SPD_W-1:0]    zero_speed_threshold,
  input  wire logic [15:0]               warn_cond,
  input  wire logic [3:0]                warning_select_a,
  input  wire logic [3:0]                warning_select_b,
  input  wire ssel_cond_s                cond,
  input  wire ssel_route_t [`SSEL_TERMINALS-1:0] output_route_select,
  input  wire logic [1:0]                feedback_type_select,
  input  wire logic                      quad_phase_a,
  input  wire logic                      quad_phase_b,
  input  wire logic                      quad_index,
  input  wire logic                      serial_feedback_line_i,
  input  wire logic                      fault_clr,
  output logic                           serial_feedback_line_o,
  output logic                           serial_feedback_line_oe,
  output logic [`SSEL_TERMINALS-1:0]     terminal_out,
  output ssel_status_s                   status_out,
  output logic [`SSEL_POS_W-1:0]         position,
  output logic [`SSEL_POS_W-1:0]         index_position,
  output logic                           index_seen,
  output logic                           phase_find_skip,
  output logic [2:0]                     hall_state,
  output logic [`SSEL_TEMP_W-1:0]        motor_temp,
  output logic                           quad_rate_fault,
  output logic                           wiring_fault,
  output logic                           serial_timeout,
  output logic                           serial_frame_err
);

  localparam logic [15:0] POLL_L = 16'(POLL_CYC);
  localparam logic [15:0] BIT_L  = 16'(BIT_CYC);
  localparam logic [15:0] TOUT_L = 16'(TIMEOUT_CYC);
  localparam logic [15:0] GAP_L  = 16'(`SSEL_QUAD_MIN_GAP);
  localparam logic [4:0]  LAST_L = 5'(`SSEL_FRAME_W - 1);

  function automatic logic [`SSEL_SPD_W-1:0] abs_diff(
    input logic signed [`SSEL_SPD_W-1:0] a,
    input logic signed [`SSEL_SPD_W-1:0] b);
    logic signed [`SSEL_SPD_W:0] d;
    d = {a[`SSEL_SPD_W-1], a} - {b[`SSEL_SPD_W-1], b};
    if (d < 0) begin
      d = -d;
    end
    abs_diff = d[`SSEL_SPD_W-1:0];
  endfunction

  function automatic logic route_pick(input ssel_status_s s, input ssel_route_t r);
    case (r)
      `SSEL_RT_MATCH:    route_pick = s.speed_match_out;
      `SSEL_RT_WARN_A:   route_pick = s.warning_out_a;
      `SSEL_RT_WARN_B:   route_pick = s.warning_out_b;
      `SSEL_RT_POS_CMD:  route_pick = s.pos_cmd_out;
      `SSEL_RT_SPD_LIM:  route_pick = s.speed_limit_out;
      `SSEL_RT_ALM_CLR:  route_pick = s.alarm_clearable_out;
      `SSEL_RT_SPD_CMD:  route_pick = s.speed_cmd_out;
      `SSEL_RT_ZERO_SPD: route_pick = s.zero_speed_out;
      default:           route_pick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Status functions and terminal routing

  ssel_status_s                   status_d, status_q;
  logic [`SSEL_TERMINALS-1:0]     term_d, term_q;

  always_comb begin
    status_d = status_q;
    term_d   = term_q;
    if (en) begin
      status_d.speed_match_out     = abs_diff(cmd_speed, act_speed) <= speed_match_width;
      status_d.warning_out_a       = warn_cond[warning_select_a];
      status_d.warning_out_b       = warn_cond[warning_select_b];
      status_d.pos_cmd_out         = cond.pos_cmd_active;
      status_d.speed_limit_out     = cond.force_ctrl_mode | cond.speed_clamped;
      status_d.alarm_clearable_out = cond.alarm_active | cond.alarm_clearable;
      status_d.speed_cmd_out       = cond.speed_ctrl_mode | cond.speed_cmd_active;
      status_d.zero_speed_out      = abs_diff(act_speed, '0) <= zero_speed_threshold;
      for (int i = 0; i < `SSEL_TERMINALS; i++) begin
        term_d[i] = route_pick(status_q, output_route_select[i]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_q <= '0;
      term_q   <= '0;
    end else begin
      status_q <= status_d;
      term_q   <= term_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quadrature decoder and serial receiver

  ssel_ser_e              ser_d, ser_q;
  logic [15:0]            cnt_d, cnt_q;
  logic [4:0]             bit_d, bit_q;
  ssel_frame_s            shf_d, shf_q;
  logic [`SSEL_SER_POS_W-1:0] last_d, last_q, ser_delta;
  logic                   so_d, so_q, soe_d, soe_q;
  logic                   qa_d, qa_q, qb_d, qb_q, qz_d, qz_q, armed_d, armed_q;
  logic [15:0]            gap_d, gap_q;
  logic [`SSEL_POS_W-1:0] pos_d, pos_q, ipos_d, ipos_q;
  logic                   iseen_d, iseen_q, skip_d, skip_q;
  logic [2:0]             hall_d, hall_q;
  logic [`SSEL_TEMP_W-1:0] temp_d, temp_q;
  logic                   rflt_d, rflt_q, wflt_d, wflt_q;
  logic                   tout_d, tout_q, ferr_d, ferr_q;
  logic                   q_move, q_up, q_bad, is_quad, frame_done;

  assign is_quad = feedback_type_select == `SSEL_FB_QUAD;
  // No edges until the phase history has been loaded once after reset
  assign q_move    = armed_q && ((quad_phase_a ^ qa_q) != (quad_phase_b ^ qb_q));
  assign q_up      = qa_q ^ quad_phase_b;
  assign q_bad     = armed_q & (quad_phase_a ^ qa_q) & (quad_phase_b ^ qb_q);
  assign ser_delta = shf_q.pos - last_q;

  always_comb begin
    ser_d = ser_q;  cnt_d = cnt_q;  bit_d = bit_q;  shf_d = shf_q;
    last_d = last_q;  qa_d = qa_q;  qb_d = qb_q;  qz_d = qz_q;
    gap_d = gap_q;  pos_d = pos_q;  ipos_d = ipos_q;  iseen_d = iseen_q;
    skip_d = skip_q;  hall_d = hall_q;  temp_d = temp_q;  armed_d = armed_q;
    rflt_d = rflt_q;  wflt_d = wflt_q;  tout_d = tout_q;  ferr_d = ferr_q;
    frame_done = 1'b0;
    if (en) begin
      // Clear first so that an event in the same cycle wins
      rflt_d = rflt_q & ~fault_clr;  wflt_d = wflt_q & ~fault_clr;
      tout_d = tout_q & ~fault_clr;  ferr_d = ferr_q & ~fault_clr;
      armed_d = 1'b1;
      qa_d = quad_phase_a;
      qb_d = quad_phase_b;
      qz_d = quad_index;
      gap_d = (gap_q == '1) ? gap_q : gap_q + 16'h0001;
      if (q_move || q_bad) begin
        gap_d = '0;
        if (q_bad || gap_q < GAP_L - 16'h0001) begin
          rflt_d = 1'b1;
        end
        if (!is_quad) begin
          wflt_d = 1'b1;
        end
      end
      if (is_quad) begin
        ser_d = SER_IDLE;
        cnt_d = '0;
        if (q_move) begin
          pos_d = q_up ? pos_q + 32'h1 : pos_q - 32'h1;
        end
        if (armed_q && quad_index && !qz_q) begin
          ipos_d  = pos_q;
          iseen_d = 1'b1;
        end
      end else begin
        case (ser_q)
          SER_IDLE: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q >= POLL_L - 16'h0001) begin
              ser_d = SER_REQ;
              cnt_d = '0;
            end
          end
          SER_REQ: begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_q >= BIT_L - 16'h0001) begin
              ser_d = SER_WAIT;
              cnt_d = '0;
            end
          end
          SER_WAIT: begin
            cnt_d = cnt_q + 16'h0001;
            if (!serial_feedback_line_i) begin
              ser_d = SER_RECV;
              cnt_d = BIT_L + (BIT_L >> 1) - 16'h0001;
              bit_d = '0;
            end else if (cnt_q >= TOUT_L - 16'h0001) begin
              ser_d  = SER_IDLE;
              cnt_d  = '0;
              tout_d = 1'b1;
            end
          end
          SER_RECV: begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == '0) begin
              shf_d = {serial_feedback_line_i, shf_q[`SSEL_FRAME_W-1:1]};
              cnt_d = BIT_L - 16'h0001;
              bit_d = bit_q + 5'h01;
              if (bit_q == LAST_L) begin
                ser_d = SER_STOP;
              end
            end
          end
          SER_STOP: begin
            cnt_d = cnt_q - 16'h0001;
            if (cnt_q == '0) begin
              ser_d = SER_IDLE;
              cnt_d = '0;
              if (serial_feedback_line_i) begin
                frame_done = 1'b1;
              end else begin
                ferr_d = 1'b1;
              end
            end
          end
          default: begin
            ser_d = SER_IDLE;
            cnt_d = '0;
          end
        endcase
        if (frame_done) begin
          last_d = shf_q.pos;
          hall_d = shf_q.hall;
          temp_d = shf_q.temp;
          if (shf_q.hall_valid) begin
            skip_d = 1'b1;
          end
          if (feedback_type_select == `SSEL_FB_SER_ABS) begin
            pos_d = {{(`SSEL_POS_W-`SSEL_SER_POS_W){1'b0}}, shf_q.pos};
          end else begin
            pos_d = pos_q + {{(`SSEL_POS_W-`SSEL_SER_POS_W){ser_delta[`SSEL_SER_POS_W-1]}},
                             ser_delta};
          end
        end
      end
    end
    so_d  = 1'b0;
    soe_d = en ? (ser_d == SER_REQ) : soe_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ser_q <= SER_IDLE;  cnt_q <= '0;  bit_q <= '0;  shf_q <= '0;
      last_q <= '0;  so_q <= 1'b0;  soe_q <= 1'b0;
      qa_q <= 1'b0;  qb_q <= 1'b0;  qz_q <= 1'b0;  gap_q <= '1;  armed_q <= 1'b0;
      pos_q <= '0;  ipos_q <= '0;  iseen_q <= 1'b0;  skip_q <= 1'b0;
      hall_q <= '0;  temp_q <= '0;  rflt_q <= 1'b0;  wflt_q <= 1'b0;
      tout_q <= 1'b0;  ferr_q <= 1'b0;
    end else begin
      ser_q <= ser_d;  cnt_q <= cnt_d;  bit_q <= bit_d;  shf_q <= shf_d;
      last_q <= last_d;  so_q <= so_d;  soe_q <= soe_d;
      qa_q <= qa_d;  qb_q <= qb_d;  qz_q <= qz_d;  gap_q <= gap_d;  armed_q <= armed_d;
      pos_q <= pos_d;  ipos_q <= ipos_d;  iseen_q <= iseen_d;  skip_q <= skip_d;
      hall_q <= hall_d;  temp_q <= temp_d;  rflt_q <= rflt_d;  wflt_q <= wflt_d;
      tout_q <= tout_d;  ferr_q <= ferr_d;
    end
  end

  assign serial_feedback_line_o  = so_q;
  assign serial_feedback_line_oe = soe_q;
  assign terminal_out     = term_q;
  assign status_out       = status_q;
  assign position         = pos_q;
  assign index_position   = ipos_q;
  assign index_seen       = iseen_q;
  assign phase_find_skip  = skip_q;
  assign hall_state       = hall_q;
  assign motor_temp       = temp_q;
  assign quad_rate_fault  = rflt_q;
  assign wiring_fault     = wflt_q;
  assign serial_timeout   = tout_q;
  assign serial_frame_err = ferr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_speed_match_set: assert property (en && abs_diff(cmd_speed, act_speed) <= speed_match_width
    |=> status_q.speed_match_out) else $error("speed match not raised");
  a_zero_speed_clr: assert property (en && abs_diff(act_speed, '0) > zero_speed_threshold
    |=> !status_q.zero_speed_out) else $error("zero speed raised above threshold");
  a_speed_limit_on: assert property (en && cond.force_ctrl_mode
    |=> status_q.speed_limit_out) else $error("speed limit missing in force control");
  a_warn_a_follow: assert property (en && warn_cond[warning_select_a]
    |=> status_q.warning_out_a) else $error("warning a not following select");
  a_route_none_low: assert property (en && output_route_select[0] == `SSEL_RT_NONE
    |=> !term_q[0]) else $error("unrouted terminal driven");
  a_route_match_out: assert property (en && output_route_select[1] == `SSEL_RT_MATCH
    && status_q.speed_match_out |=> term_q[1]) else $error("routed status missing");
  a_quad_no_serial: assert property (en && is_quad
    |=> ser_q == SER_IDLE && !soe_q) else $error("serial active in quadrature mode");
  a_quad_count_up: assert property (en && is_quad && q_move && q_up
    |=> pos_q == $past(pos_q) + 32'h1) else $error("quadrature count up wrong");
  a_oe_only_req: assert property (soe_q |-> ser_q == SER_REQ && !so_q)
    else $error("serial pair driven outside request");
  a_hall_skip_set: assert property (frame_done && shf_q.hall_valid
    |=> skip_q ##1 skip_q) else $error("phase find skip not held");
  a_wiring_fault_set: assert property (en && !is_quad && q_move
    |=> wflt_q) else $error("wiring fault not flagged");

  c_quad_count: cover property (en && is_quad && q_move ##1 en && q_move);
  c_serial_frame: cover property (frame_done && shf_q.hall_valid);
  c_terminal_high: cover property (term_q[0] ##1 !term_q[0]);

endmodule

`default_nettype wire

/* tb/ssel_enc_model.sv */
/*
  Behavioural feedback encoder on the serial pair: answers each device
  request with one frame once the device releases the line.
  Assumes the bench resolves the pair and biases it high when undriven.
*/
`timescale 1ns/1ps
`default_nettype none

module ssel_enc_model
  import ssel_pkg::*;
#(
  parameter int BIT_CYC = 4
) (
  input  wire logic        clk,
  input  wire logic        line_oe,
  input  wire ssel_frame_s frame,
  input  wire logic        mute,
  input  wire logic        bad_stop,
  output logic             drv,
  output logic             bit_v
);
  logic p;
  int   i;

  initial begin
    drv = 1'b0;
    bit_v = 1'b1;
    p = 1'b0;
    forever begin
      @(posedge clk);
      // Talk only after the device has released the pair
      if (p && !line_oe && !mute) begin
        repeat (3) @(posedge clk);
        drv <= 1'b1;
        bit_v <= 1'b0;
        repeat (BIT_CYC) @(posedge clk);
        for (i = 0; i < $bits(frame); i++) begin
          bit_v <= frame[i];
          repeat (BIT_CYC) @(posedge clk);
        end
        bit_v <= !bad_stop;
        repeat (BIT_CYC) @(posedge clk);
        drv <= 1'b0;
      end
      p = line_oe;
    end
  end
endmodule

`default_nettype wire

/* tb/tb.sv */
/*
  Self-checking bench of the status and encoder select block: status table,
  terminal routing, quadrature decoding, serial frames and fault flags.
  Assumes ssel_top and ssel_enc_model; clk 50 MHz; short serial timings.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import ssel_pkg::*;
;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] act;
    logic [15:0] wid;
    logic [15:0] thr;
    logic [15:0] wc;
    logic [3:0]  sa;
    logic [3:0]  sb;
    logic [6:0]  cnd;
    logic [7:0]  exp;
  } ssel_row_s;

  ssel_row_s rows [8] = '{
    '{16'h0064, 16'h005A, 16'h000A, 16'h0005, 16'h0000, 4'h0, 4'h0, 7'h00, 8'h01},
    '{16'h0064, 16'h0059, 16'h000A, 16'h0005, 16'h0000, 4'h0, 4'h0, 7'h40, 8'h08},
    '{16'hFFFB, 16'h0005, 16'h000A, 16'h0005, 16'h0000, 4'h0, 4'h0, 7'h20, 8'h91},
    '{16'h0000, 16'hFFFA, 16'h0005, 16'h0005, 16'h0004, 4'h2, 4'h3, 7'h10, 8'h12},
    '{16'h03E8, 16'hFC18, 16'hFFFF, 16'h0000, 16'h8000, 4'hF, 4'hF, 7'h08, 8'h27},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h0, 4'h0, 7'h04, 8'hA1},
    '{16'h012C, 16'h0000, 16'h000A, 16'h0000, 16'h0000, 4'h0, 4'h0, 7'h02, 8'hC0},
    '{16'h012C, 16'h0001, 16'h000A, 16'h0000, 16'h0000, 4'h0, 4'h0, 7'h01, 8'h40}};

  logic clk, rst_n, en, qa, qb, qz, fault_clr, line_in, line_o, line_oe, drv, bit_v;
  logic mute, bad_stop, index_seen, skip, rate_f, wire_f, ser_to, frame_err;
  logic signed [15:0] cmd_speed, act_speed;
  logic [15:0] wid, thr, warn_cond;
  logic [3:0] sel_a, sel_b;
  logic [1:0] fb_type;
  logic [5:0] terminal_out, e6;
  logic [31:0] position, index_position;
  logic [2:0] hall_state;
  logic [7:0] motor_temp;
  ssel_cond_s cond;
  ssel_route_t [5:0] route;
  ssel_status_s status_out;
  ssel_frame_s frame;
  int miscompares, comparisons, cycles, i, t;

  ssel_top #(.POLL_CYC(20), .BIT_CYC(4), .TIMEOUT_CYC(50)) i_ssel_top (
    .clk(clk), .rst_n(rst_n), .en(en), .cmd_speed(cmd_speed), .act_speed(act_speed),
    .speed_match_width(wid), .zero_speed_threshold(thr), .warn_cond(warn_cond),
    .warning_select_a(sel_a), .warning_select_b(sel_b), .cond(cond),
    .output_route_select(route), .feedback_type_select(fb_type), .quad_phase_a(qa),
    .quad_phase_b(qb), .quad_index(qz), .serial_feedback_line_i(line_in),
    .fault_clr(fault_clr), .serial_feedback_line_o(line_o),
    .serial_feedback_line_oe(line_oe), .terminal_out(terminal_out), .status_out(status_out),
    .position(position), .index_position(index_position), .index_seen(index_seen),
    .phase_find_skip(skip), .hall_state(hall_state), .motor_temp(motor_temp),
    .quad_rate_fault(rate_f), .wiring_fault(wire_f), .serial_timeout(ser_to),
    .serial_frame_err(frame_err));

  ssel_enc_model #(.BIT_CYC(4)) i_ssel_enc_model (
    .clk(clk), .line_oe(line_oe), .frame(frame), .mute(mute), .bad_stop(bad_stop),
    .drv(drv), .bit_v(bit_v));

  // Undriven pair is biased high
  assign line_in = line_oe ? line_o : (drv ? bit_v : 1'b1);

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic qs(input logic a, input logic b);
    @(posedge clk);
    qa <= a;
    qb <= b;
    repeat (13) @(posedge clk);
    #1;
  endtask

  // Waits for n device requests on the pair
  task automatic wait_req(input int n);
    int k;
    int c;
    logic p;
    k = 0;
    c = 0;
    p = line_oe;
    while (k < n && c < 1000) begin
      @(posedge clk);
      #1;
      c++;
      if (line_oe && !p) k++;
      p = line_oe;
    end
    chk(k, n);
    chk({line_oe, line_o}, 2'b10);
  endtask

  task automatic clr();
    @(posedge clk);
    fault_clr <= 1'b1;
    @(posedge clk);
    fault_clr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst_n = 0; en = 1; qa = 0; qb = 0; qz = 0; fault_clr = 0;
    cmd_speed = '0; act_speed = '0; wid = '0; thr = '0; warn_cond = '0;
    sel_a = '0; sel_b = '0; cond = '0; route = '0; fb_type = 2'h0;
    mute = 1; bad_stop = 0; frame = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(status_out, 0);
    chk(terminal_out, 0);
    @(posedge clk);
    #1;
    chk(status_out, 8'h81);
    chk(terminal_out, 0);
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      cmd_speed <= rows[i].cmd; act_speed <= rows[i].act; wid <= rows[i].wid;
      thr <= rows[i].thr; warn_cond <= rows[i].wc; sel_a <= rows[i].sa;
      sel_b <= rows[i].sb; cond <= ssel_cond_s'(rows[i].cnd);
      for (t = 0; t < 6; t++) begin
        route[t] <= 4'((3 * i + t) % 16);
        e6[t] = ((3 * i + t) % 16 inside {[1:8]}) ? rows[i].exp[(3 * i + t) % 16 - 1] : 1'b0;
      end
      repeat (3) @(posedge clk);
      #1;
      chk(status_out, rows[i].exp);
      chk(terminal_out, e6);
    end
    qs(0, 1); qs(1, 1); qs(1, 0); qs(0, 0);
    chk(position, 4);
    chk(rate_f, 0);
    @(posedge clk);
    qz <= 1'b1;
    repeat (3) @(posedge clk);
    qz <= 1'b0;
    qs(1, 0);
    chk(index_position, 4);
    chk(index_seen, 1);
    chk(position, 3);
    @(posedge clk);
    qb <= 1'b1;
    @(posedge clk);
    qa <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(rate_f, 1);
    @(posedge clk);
    fb_type <= 2'h1;
    qs(1, 1);
    chk(wire_f, 1);
    wait_req(2);
    chk(ser_to, 1);
    @(posedge clk);
    mute <= 1'b0;
    bad_stop <= 1'b1;
    wait_req(2);
    chk(frame_err, 1);
    chk(skip, 0);
    @(posedge clk);
    bad_stop <= 1'b0;
    frame <= '{8'h3C, 3'h5, 1'b1, 16'h1234};
    fb_type <= 2'h2;
    clr();
    wait_req(3);
    chk({rate_f, wire_f, ser_to, frame_err}, 0);
    chk(position, 32'h00001234);
    chk({hall_state, motor_temp}, 11'h53C);
    chk(skip, 1);
    @(posedge clk);
    frame <= '{8'h41, 3'h3, 1'b0, 16'h1200};
    fb_type <= 2'h1;
    wait_req(3);
    chk(position, 32'h00001200);
    chk({hall_state, motor_temp}, 11'h341);
    chk(skip, 1);
    // Clock enable low freezes status and fault state
    @(posedge clk);
    en <= 1'b0;
    cond <= '0;
    qa <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(status_out, 8'h40);
    chk(wire_f, 0);
    chk(position, 32'h00001200);
    @(posedge clk);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(status_out, 8'h00);
    chk(wire_f, 1);
    // Reset in mid-run with phase B high must not show a false edge
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({skip, index_seen, wire_f, line_oe, hall_state, motor_temp}, 0);
    chk(position, 0);
    repeat (2) @(posedge clk);
    #1;
    chk(wire_f, 0);
    give_verdict();
  end
endmodule

`default_nettype wire
